// ### hw/dma_global_control.v
// Contract
// - Masked status shows channels driving second line
// - Writing ones clears channel pending; resets zero
// - Mask bit n passes channel n
// - Four timers, dividend high, divisor low
// - Timer pulses average dividend/divisor per cycle, at most one per cycle
// - Start bit triggers enabled idle channel
// - Complement bit inverts accumulator on read
// - Reverse bit bit-reverses accumulator on read
// - Byte-reverse bit swaps observed data bytes
// - Monitor sees data after channel swap
// - Monitor watches selected channel while enabled
// - Accumulator updates on each monitored read
// - Debug register reports three queue fills
// - Cancel bit aborts channel transfer sequence
// - Cancel bit stays until channel has nothing in flight
//
// The address-and-strobe port was left to the implementer.
`include "dma_global_control_regs.vh"
`default_nettype none

module dma_global_control #(
    parameter NCHAN  = 16,
    parameter NTIMER = 4
) (
    // Clock and reset
    input  wire                  sys_clk,
    input  wire                  rstn,
    // Register port
    input  wire [11:0]           regAddr,
    input  wire [31:0]           regWdata,
    input  wire                  regWrite,
    input  wire                  regRead,
    output reg  [31:0]           regRdata,
    // Channel status and pending interrupts
    input  wire [NCHAN-1:0]      chanEnable,
    input  wire [NCHAN-1:0]      chanBusy,
    input  wire [NCHAN-1:0]      chanIrqSet,
    output wire [NCHAN-1:0]      chanIrqPending,
    output wire                  dmaIrq1,
    // Channel triggers and cancels
    output wire [NCHAN-1:0]      chanTrigger,
    output wire [NCHAN-1:0]      chanCancel,
    input  wire [NCHAN-1:0]      chanInFlight,
    // Pacing request pulses
    output wire [NTIMER-1:0]     pacingRequestPulse,
    // Read data after channel byte swap
    input  wire                  readValid,
    input  wire [3:0]            readChannel,
    input  wire [31:0]           readData,
    // Queue fill levels
    input  wire [7:0]            readAddrQueueFill,
    input  wire [7:0]            writeAddrQueueFill,
    input  wire [7:0]            xferDataQueueFill,
    // Block interrupt
    output wire                  blockIrq
);

    // State
    wire [NCHAN-1:0]           pending_r;
    reg  [NCHAN-1:0]           irq1ChannelMask_r;
    reg  [NTIMER-1:0]          wrRatio;
    reg  [11:0]                ratioAddr;
    wire [32*NTIMER-1:0]       ratioFlat;
    reg  [NCHAN-1:0]           start_r;
    reg  [NCHAN-1:0]           cancel_r;
    reg  [`CFG_WIDTH-1:0]      monitorConfig_r;
    reg  [31:0]                accumulator_r;
    reg  [31:0]                accumulator_nxt;
    wire [`EVT_WIDTH-1:0]      evtStatus_r;
    reg  [`EVT_WIDTH-1:0]      evtMask_r;
    reg  [31:0]                readMux;
    reg  [31:0]                feedData;
    reg  [31:0]                crcState;
    reg  [31:0]                outView;
    reg                        crcFb;
    integer                    i;
    integer                    b;
    integer                    k;

    // Write decodes
    wire wrMask    = regWrite && regAddr == `OFS_IRQ1_CHANNEL_MASK;
    wire wrStatus  = regWrite && regAddr == `OFS_IRQ1_MASKED_STATUS;
    wire wrStart   = regWrite && regAddr == `OFS_CHANNEL_GROUP_START;
    wire wrConfig  = regWrite && regAddr == `OFS_MONITOR_CONFIG;
    wire wrAccum   = regWrite && regAddr == `OFS_MONITOR_ACCUMULATOR;
    wire wrCancel  = regWrite && regAddr == `OFS_CHANNEL_CANCEL;
    wire wrEvtStat = regWrite && regAddr == `OFS_EVENT_STATUS;
    wire wrEvtMask = regWrite && regAddr == `OFS_EVENT_MASK;

    // Second interrupt line
    wire [NCHAN-1:0] maskedStatus = pending_r & irq1ChannelMask_r;
    assign chanIrqPending = pending_r;
    assign dmaIrq1        = |maskedStatus;

    // Pending flags: a new event wins over a clear in the same cycle
    sticky_flags #(
        .W (NCHAN)
    ) pendingFlags (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .setBits   (chanIrqSet),
        .clearEn   (wrStatus),
        .clearBits (regWdata[NCHAN-1:0]),
        .flags_r   (pending_r)
    );

    // Second-line channel mask
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            irq1ChannelMask_r <= {NCHAN{1'b0}};
        else if (wrMask)
            irq1ChannelMask_r <= regWdata[NCHAN-1:0];
    end

    // Pacing timers: one ratio register and fractional divider each
    always @*
    begin
        wrRatio   = {NTIMER{1'b0}};
        ratioAddr = `OFS_PACING_RATIO_0;
        for (k = 0; k < NTIMER; k = k + 1)
        begin
            wrRatio[k] = regWrite && regAddr == ratioAddr;
            ratioAddr  = ratioAddr + `PACING_STRIDE;
        end
    end

    genvar t;
    generate
        for (t = 0; t < NTIMER; t = t + 1)
        begin : gPace
            pacing_timer pacing_timer_inst (
                .sys_clk            (sys_clk),
                .rstn               (rstn),
                .ratioWrite         (wrRatio[t]),
                .ratioWdata         (regWdata),
                .ratio_r            (ratioFlat[32*t +: 32]),
                .pacingRequestPulse (pacingRequestPulse[t])
            );
        end
    endgenerate

    // Group start: one-cycle trigger, never stored for read
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            start_r <= {NCHAN{1'b0}};
        else if (wrStart)
            start_r <= regWdata[NCHAN-1:0];
        else
            start_r <= {NCHAN{1'b0}};
    end
    assign chanTrigger = start_r & chanEnable & ~chanBusy;

    // Cancel: held until the channel has nothing in flight
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cancel_r <= {NCHAN{1'b0}};
        else
            cancel_r <= (wrCancel ? regWdata[NCHAN-1:0] : {NCHAN{1'b0}})
                        | (cancel_r & chanInFlight);
    end
    assign chanCancel = cancel_r;
    // Done: a held cancel whose channel has drained
    wire cancelDone = |(cancel_r & ~chanInFlight);

    // Monitor configuration
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            monitorConfig_r <= {`CFG_WIDTH{1'b0}};
        else if (wrConfig)
            monitorConfig_r <= regWdata[`CFG_WIDTH-1:0];
    end

    // Only the selected channel's reads, only while enabled
    wire monitorHit = monitorConfig_r[`CFG_ENABLE] && readValid &&
                      readChannel == monitorConfig_r[`CFG_CHAN_HI:`CFG_CHAN_LO];

    // Checksum datapath; input already carries the channel byte swap
    always @*
    begin
        feedData = monitorConfig_r[`CFG_BYTE_REV] ?
                   {readData[7:0], readData[15:8], readData[23:16], readData[31:24]}
                   : readData;
        crcState = accumulator_r;
        crcFb    = 1'b0;
        case (monitorConfig_r[`CFG_ALGO_HI:`CFG_ALGO_LO])
            `ALGO_CRC32:
            begin
                for (b = 31; b >= 0; b = b - 1)
                begin
                    crcFb    = crcState[31] ^ feedData[b];
                    crcState = {crcState[30:0], 1'b0} ^ (crcFb ? `CRC32_POLY : 32'h00000000);
                end
            end
            `ALGO_CRC32_REV:
            begin
                for (b = 0; b < 32; b = b + 1)
                begin
                    crcFb    = crcState[31] ^ feedData[b];
                    crcState = {crcState[30:0], 1'b0} ^ (crcFb ? `CRC32_POLY : 32'h00000000);
                end
            end
            `ALGO_SUM:
                crcState = accumulator_r + feedData;
            default:
                crcState = accumulator_r ^ feedData;
        endcase
        accumulator_nxt = crcState;
    end

    // A seed write takes priority over an observed read
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            accumulator_r <= 32'h00000000;
        else if (wrAccum)
            accumulator_r <= regWdata;
        else if (monitorHit)
            accumulator_r <= accumulator_nxt;
    end

    // Read view of the accumulator: transforms only on the bus path
    always @*
    begin
        outView = accumulator_r;
        if (monitorConfig_r[`CFG_RESULT_REV])
            for (i = 0; i < 32; i = i + 1)
                outView[i] = accumulator_r[31-i];
        if (monitorConfig_r[`CFG_RESULT_INV])
            outView = ~outView;
    end

    // Block events: sticky, set wins over write-one-to-clear
    wire [`EVT_WIDTH-1:0] evtSet = {cancelDone, monitorHit};
    sticky_flags #(
        .W (`EVT_WIDTH)
    ) eventFlags (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .setBits   (evtSet),
        .clearEn   (wrEvtStat),
        .clearBits (regWdata[`EVT_WIDTH-1:0]),
        .flags_r   (evtStatus_r)
    );

    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            evtMask_r <= {`EVT_WIDTH{1'b0}};
        else if (wrEvtMask)
            evtMask_r <= regWdata[`EVT_WIDTH-1:0];
    end
    assign blockIrq = |(evtStatus_r & evtMask_r);

    // Register read decode; reserved bits read zero
    always @*
    begin
        readMux = 32'h00000000;
        case (regAddr)
            `OFS_IRQ1_CHANNEL_MASK:   readMux[NCHAN-1:0] = irq1ChannelMask_r;
            `OFS_IRQ1_MASKED_STATUS:  readMux[NCHAN-1:0] = maskedStatus;
            `OFS_PACING_RATIO_0:      readMux = ratioFlat[31:0];
            `OFS_PACING_RATIO_1:      readMux = ratioFlat[63:32];
            `OFS_PACING_RATIO_2:      readMux = ratioFlat[95:64];
            `OFS_PACING_RATIO_3:      readMux = ratioFlat[127:96];
            `OFS_CHANNEL_GROUP_START: readMux = 32'h00000000;
            `OFS_MONITOR_CONFIG:      readMux[`CFG_WIDTH-1:0] = monitorConfig_r;
            `OFS_MONITOR_ACCUMULATOR: readMux = outView;
            `OFS_QUEUE_OCCUPANCY:     readMux = {8'h00, readAddrQueueFill,
                                                 writeAddrQueueFill, xferDataQueueFill};
            `OFS_CHANNEL_CANCEL:      readMux[NCHAN-1:0] = cancel_r;
            `OFS_EVENT_STATUS:        readMux[`EVT_WIDTH-1:0] = evtStatus_r;
            `OFS_EVENT_MASK:          readMux[`EVT_WIDTH-1:0] = evtMask_r;
            default:                  readMux = 32'h00000000;
        endcase
    end

    // Read data stands for one cycle, zero otherwise
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            regRdata <= 32'h00000000;
        else if (regRead)
            regRdata <= readMux;
        else
            regRdata <= 32'h00000000;
    end

endmodule // dma_global_control

// Fractional divider: adds the dividend each cycle, wraps at the divisor
module pacing_timer (
    // Clock and reset
    input  wire                  sys_clk,
    input  wire                  rstn,
    // Ratio register
    input  wire                  ratioWrite,
    input  wire [31:0]           ratioWdata,
    output reg  [31:0]           ratio_r,
    // Request pulse
    output reg                   pacingRequestPulse
);

    // Remainder of the fractional division
    reg  [16:0]                  accum_r;
    wire [15:0]                  dividend = ratio_r[`RATIO_DIVIDEND_HI:`RATIO_DIVIDEND_LO];
    wire [15:0]                  divisor  = ratio_r[`RATIO_DIVISOR_HI:`RATIO_DIVISOR_LO];
    wire [16:0]                  sum      = accum_r + {1'b0, dividend};
    wire                         running  = divisor != `RATIO_OFF;
    wire                         hit      = running && sum >= {1'b0, divisor};
    // A ratio of one or more fires every cycle; the remainder must not grow
    wire                         saturate = dividend >= divisor;

    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ratio_r            <= `RATIO_RESET;
            accum_r            <= 17'h00000;
            pacingRequestPulse <= 1'b0;
        end
        else
        begin
            if (ratioWrite)
                ratio_r <= ratioWdata;
            if (ratioWrite || saturate)
                accum_r <= 17'h00000;
            else if (hit)
                accum_r <= sum - {1'b0, divisor};
            else if (running)
                accum_r <= sum;
            pacingRequestPulse <= hit;
        end
    end

endmodule // pacing_timer

// Sticky flags: set by hardware, cleared by writing ones; a set wins
module sticky_flags #(
    parameter W = 16
) (
    // Clock and reset
    input  wire                  sys_clk,
    input  wire                  rstn,
    // Events and software clear
    input  wire [W-1:0]          setBits,
    input  wire                  clearEn,
    input  wire [W-1:0]          clearBits,
    // Flags
    output reg  [W-1:0]          flags_r
);

    // Clear first, then set, so a same-cycle event survives
    always @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            flags_r <= {W{1'b0}};
        else if (clearEn)
            flags_r <= (flags_r & ~clearBits) | setBits;
        else
            flags_r <= flags_r | setBits;
    end

endmodule // sticky_flags

`default_nettype wire

// ### hw/dma_global_control_regs.vh
`ifndef DMA_GLOBAL_CONTROL_REGS_VH
`define DMA_GLOBAL_CONTROL_REGS_VH
// Register byte offsets
`define OFS_IRQ1_CHANNEL_MASK      12'h414
`define OFS_IRQ1_MASKED_STATUS     12'h41c
`define OFS_PACING_RATIO_0         12'h420
`define OFS_PACING_RATIO_1         12'h424
`define OFS_PACING_RATIO_2         12'h428
`define OFS_PACING_RATIO_3         12'h42c
`define PACING_STRIDE              12'h004
`define OFS_CHANNEL_GROUP_START    12'h430
`define OFS_MONITOR_CONFIG         12'h434
`define OFS_MONITOR_ACCUMULATOR    12'h438
`define OFS_QUEUE_OCCUPANCY        12'h440
`define OFS_CHANNEL_CANCEL         12'h444
`define OFS_EVENT_STATUS           12'h450
`define OFS_EVENT_MASK             12'h454
// Pacing ratio fields
`define RATIO_DIVIDEND_HI          31
`define RATIO_DIVIDEND_LO          16
`define RATIO_DIVISOR_HI           15
`define RATIO_DIVISOR_LO           0
`define RATIO_OFF                  16'h0000
`define RATIO_RESET                32'h00000000
// Monitor configuration fields
`define CFG_ENABLE                 0
`define CFG_CHAN_HI                4
`define CFG_CHAN_LO                1
`define CFG_ALGO_HI                8
`define CFG_ALGO_LO                5
`define CFG_BYTE_REV               9
`define CFG_RESULT_REV             10
`define CFG_RESULT_INV             11
`define CFG_WIDTH                  12
// Checksum algorithm codes
`define ALGO_CRC32                 4'h0
`define ALGO_CRC32_REV             4'h1
`define ALGO_SUM                   4'hf
`define CRC32_POLY                 32'h04c11db7
// Event status bits
`define EVT_MONITOR_UPDATE         0
`define EVT_CANCEL_DONE            1
`define EVT_WIDTH                  2
`endif

// ### tb/dma_global_control_checker.sv
`default_nettype none
module dma_global_control_checker #(
    parameter NCHAN  = 16,
    parameter NTIMER = 4
) (
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             rstn,
    // Register port
    input wire logic [11:0]      regAddr,
    input wire logic [31:0]      regWdata,
    input wire logic             regWrite,
    input wire logic             regRead,
    input wire logic [31:0]      regRdata,
    // Channel side
    input wire logic [NCHAN-1:0] chanEnable,
    input wire logic [NCHAN-1:0] chanBusy,
    input wire logic [NCHAN-1:0] chanIrqSet,
    input wire logic [NCHAN-1:0] chanIrqPending,
    input wire logic             dmaIrq1,
    input wire logic [NCHAN-1:0] chanTrigger,
    input wire logic [NCHAN-1:0] chanCancel,
    input wire logic [NCHAN-1:0] chanInFlight,
    // Queue levels
    input wire logic [7:0]       readAddrQueueFill,
    input wire logic [7:0]       writeAddrQueueFill,
    input wire logic [7:0]       xferDataQueueFill
);
    timeunit 1ns;
    timeprecision 100ps;
    wire startWr  = regWrite && regAddr == 12'h430;
    wire cancelWr = regWrite && regAddr == 12'h444;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    a_trigger_cause: assert property (chanTrigger == (($past(startWr) ?
        $past(regWdata[NCHAN-1:0]) : '0) & chanEnable & ~chanBusy)) else $error("bad trigger");
    a_read_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside read cycle");
    a_start_zero: assert property (regRead && regAddr == 12'h430 |=> regRdata == 32'h0)
        else $error("start register not zero");
    a_fill_read: assert property (regRead && regAddr == 12'h440 |=> regRdata ==
        {8'h0, $past(readAddrQueueFill), $past(writeAddrQueueFill), $past(xferDataQueueFill)})
        else $error("bad fill levels");
    a_irq_quiet: assert property (chanIrqPending == '0 |-> !dmaIrq1)
        else $error("irq line without pending");
    a_pending_set: assert property (|chanIrqSet |=>
        (chanIrqPending & $past(chanIrqSet)) == $past(chanIrqSet)) else $error("pending lost");
    a_status_subset: assert property (regRead && regAddr == 12'h41c |=>
        (regRdata & ~{16'h0, $past(chanIrqPending)}) == 32'h0 && (regRdata == 32'h0 || $past(dmaIrq1)))
        else $error("status not masked pending");
    a_cancel_set: assert property (cancelWr |=>
        (chanCancel & $past(regWdata[NCHAN-1:0])) == $past(regWdata[NCHAN-1:0]))
        else $error("cancel not set");
    a_cancel_hold: assert property ((~chanCancel & $past(chanCancel & chanInFlight)) == '0)
        else $error("cancel dropped early");
    a_cancel_clear: assert property (!cancelWr |=>
        (chanCancel & $past(chanCancel & ~chanInFlight)) == '0) else $error("cancel stuck");
    c_trigger: cover property (|chanTrigger);
    c_irq: cover property (dmaIrq1);
    c_drain: cover property ($fell(|chanCancel));
endmodule // dma_global_control_checker

bind dma_global_control dma_global_control_checker #(.NCHAN(NCHAN), .NTIMER(NTIMER))
    dma_global_control_checker_inst (.sys_clk, .rstn, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata, .chanEnable, .chanBusy, .chanIrqSet, .chanIrqPending, .dmaIrq1,
    .chanTrigger, .chanCancel, .chanInFlight, .readAddrQueueFill, .writeAddrQueueFill,
    .xferDataQueueFill);
`default_nettype wire

// ### tb/test_dma_global_control.sv
`default_nettype none
module test_dma_global_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 0, rstn = 0, regWrite = 0, regRead = 0, readValid = 0;
    logic [11:0] regAddr = 12'h0;
    logic [31:0] regWdata = 32'h0, readData = 32'h0, regRdata;
    logic [15:0] chanEnable = 16'h0, chanBusy = 16'h0, chanIrqSet = 16'h0, chanInFlight = 16'h0;
    logic [15:0] chanIrqPending, chanTrigger, chanCancel;
    logic [7:0]  readAddrQueueFill = 8'h0, writeAddrQueueFill = 8'h0, xferDataQueueFill = 8'h0;
    logic [3:0]  readChannel = 4'h0, pacingRequestPulse;
    logic        dmaIrq1, blockIrq;
    int          mismatches = 0, n_tests = 0, cnt[4];
    logic [11:0] rz[7] = '{12'h41c, 12'h430, 12'h438, 12'h444, 12'h000, 12'h420, 12'h440};

    dma_global_control dma_global_control_inst (.sys_clk, .rstn, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .chanEnable, .chanBusy, .chanIrqSet, .chanIrqPending,
        .dmaIrq1, .chanTrigger, .chanCancel, .chanInFlight, .pacingRequestPulse, .readValid,
        .readChannel, .readData, .readAddrQueueFill, .writeAddrQueueFill, .xferDataQueueFill,
        .blockIrq);

    always #2 sys_clk = ~sys_clk;

    function automatic logic [31:0] rev(input logic [31:0] v);
        for (int i = 0; i < 32; i++)
            rev[i] = v[31-i];
    endfunction
    function automatic logic [31:0] crc(input logic [31:0] s, input logic [31:0] v);
        for (int i = 31; i >= 0; i--)
            s = {s[30:0], 1'b0} ^ ((s[31] ^ v[i]) ? 32'h04c11db7 : 32'h0);
        return s;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    task automatic feed(input logic [3:0] ch, input logic [31:0] d);
        @(posedge sys_clk);
        readValid <= 1'b1;
        readChannel <= ch;
        readData <= d;
        @(posedge sys_clk);
        readValid <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        logic [31:0] d;
        int e;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (rz[i]) rdc(rz[i], 32'h0);
        wr(12'h000, 32'hffffffff);
        rdc(12'h000, 32'h0);
        readAddrQueueFill <= 8'h12;
        writeAddrQueueFill <= 8'h34;
        xferDataQueueFill <= 8'h56;
        rdc(12'h440, 32'h00123456);
        chanEnable <= 16'h0005;
        chanBusy <= 16'h0004;
        wr(12'h430, 32'h0000000f);
        #1 chk({16'h0, chanTrigger}, 32'h1);
        rdc(12'h430, 32'h0);
        $display("trigger test done");
        wr(12'h414, 32'h3);
        @(posedge sys_clk);
        chanIrqSet <= 16'h0006;
        @(posedge sys_clk);
        chanIrqSet <= 16'h0;
        rdc(12'h41c, 32'h2);
        chk({31'h0, dmaIrq1}, 32'h1);
        wr(12'h41c, 32'h2);
        #1 chk({31'h0, dmaIrq1}, 32'h0);
        rdc(12'h41c, 32'h0);
        $display("irq test done");
        wr(12'h454, 32'h2);
        chanInFlight <= 16'h0008;
        wr(12'h444, 32'h8);
        #1 chk({16'h0, chanCancel}, 32'h8);
        rdc(12'h444, 32'h8);
        chanInFlight <= 16'h0;
        d = 32'h8;
        for (int k = 0; k < 20 && d !== 32'h0; k++) rd(12'h444, d);
        chk(d, 32'h0);
        if (d !== 32'h0)
            print_verdict();
        chk({31'h0, blockIrq}, 32'h1);
        wr(12'h454, 32'h0);
        #1 chk({31'h0, blockIrq}, 32'h0);
        wr(12'h450, 32'h3);
        rdc(12'h450, 32'h0);
        $display("cancel test done");
        for (int t = 0; t < 4; t++)
            wr(12'h420 + 12'(4*t), t == 3 ? {16'd2, 16'd1} : {16'd1, 16'(t+2)});
        for (int t = 0; t < 4; t++)
            rdc(12'h420 + 12'(4*t), t == 3 ? {16'd2, 16'd1} : {16'd1, 16'(t+2)});
        repeat (60)
        begin
            @(posedge sys_clk);
            #1;
            foreach (cnt[t]) cnt[t] += int'(pacingRequestPulse[t]);
        end
        foreach (cnt[t])
        begin
            e = t == 3 ? 60 : 60 / (t + 2);
            chk({31'h0, cnt[t] >= e - 1 && cnt[t] <= e + 1}, 32'h1);
        end
        $display("pacing test done");
        wr(12'h434, 32'h1e7);
        wr(12'h438, 32'h10);
        feed(4'h3, 32'h01020304);
        feed(4'h2, 32'hffffffff);
        rdc(12'h438, 32'h01020314);
        wr(12'h434, 32'h3e7);
        feed(4'h3, 32'h01020304);
        rdc(12'h438, 32'h05050515);
        wr(12'h434, 32'h9e6);
        feed(4'h3, 32'h1);
        rdc(12'h438, ~32'h05050515);
        wr(12'h434, 32'hde6);
        rdc(12'h438, ~rev(32'h05050515));
        wr(12'h434, 32'h5e6);
        rdc(12'h438, rev(32'h05050515));
        wr(12'h434, 32'h045);
        wr(12'h438, 32'h0f0f0f0f);
        feed(4'h2, 32'hff00ff00);
        rdc(12'h438, 32'hf00ff00f);
        wr(12'h434, 32'h005);
        wr(12'h438, 32'hffffffff);
        feed(4'h2, 32'h12345678);
        rdc(12'h438, crc(32'hffffffff, 32'h12345678));
        $display("monitor test done");
        print_verdict();
    end
endmodule // test_dma_global_control
`default_nettype wire
